// *** src/fdrc_read_cmd.v ***
// Read/read-deleted command interpreter with APB access and step timer
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "fdrc_consts.vh"
// Behaviour
// - Step pulses are spaced by a programmable 1 to 16 ms interval.
// - Four post-command flag bytes hold status of the last command.
// - Flag bytes are readable only in the result phase after execution.
// - Flag bytes are separate from the main status seen with select low.
// - Scan with stride one handles every contiguous sector.
// - Scan with stride two handles only alternate sectors.
// - The opcode skip flag decides if sectors whose mark does not match the command are passed over.
// - The sectors-per-cylinder value bounds the walk along the track.
// - The record byte names the first sector; the result returns the ID.
// - The two drive-select bits address the drive used by the command.
// - Select low gives the main status, select high the data register.
// - Multi-track continues onto the second head of the cylinder.
module fdrc_read_cmd #(
  parameter UNIT_CYC = `FDRC_STEP_UNIT_CYC
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         irq,
  output reg  [1:0]  drive_sel,
  output reg         head_sel,
  output reg  [7:0]  sector_num,
  output reg         sector_req,
  input  wire        sector_done,
  input  wire        sector_deleted,
  output reg         step_out
);

  // ----------------------------------------------------------------
  // Phases
  // ----------------------------------------------------------------
  localparam [1:0] PH_CMD  = 2'd0;
  localparam [1:0] PH_REQ  = 2'd1;
  localparam [1:0] PH_WAIT = 2'd2;
  localparam [1:0] PH_RES  = 2'd3;

  reg  [1:0]  phase_r;
  reg  [3:0]  cmd_idx_r;
  reg  [2:0]  res_idx_r;
  reg  [7:0]  param_r [0:8];
  reg  [7:0]  flags_r [0:3];
  reg  [7:0]  cur_r;
  reg  [15:0] ctrl_r;
  reg  [1:0]  istat_r;
  reg  [1:0]  imask_r;
  reg  [7:0]  steps_r;
  reg  [23:0] timer_r;
  reg         step_busy_r;
  integer     i;

  function is_read_op;
    input [7:0] op;
    begin
      is_read_op = (op[4:0] == `FDRC_OP_READ) ||
                   (op[4:0] == `FDRC_OP_READ_DEL);
    end
  endfunction

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  wire        xfer     = psel & penable & pready;
  wire        wr       = xfer & pwrite;
  wire        rd       = xfer & ~pwrite;
  wire        a_data   = (paddr == `FDRC_ADDR_DATA);
  wire        a_msr    = (paddr == `FDRC_ADDR_MSR);
  wire        a_ctrl   = (paddr == `FDRC_ADDR_CTRL);
  wire        a_step   = (paddr == `FDRC_ADDR_STEP);
  wire        a_istat  = (paddr == `FDRC_ADDR_ISTAT);
  wire        a_imask  = (paddr == `FDRC_ADDR_IMASK);
  wire        mapped   = a_data | a_msr | a_ctrl | a_step | a_istat | a_imask;
  wire [7:0]  opcode   = param_r[0];
  wire        multi    = opcode[7];
  wire        omit_del = opcode[5];
  wire        want_del = (opcode[4:0] == `FDRC_OP_READ_DEL);
  wire [1:0]  stride   = ctrl_r[`FDRC_CTRL_STRD_LSB +: 2];
  wire        scan_on  = ctrl_r[`FDRC_CTRL_SCAN_BIT];
  wire [7:0]  spc      = ctrl_r[`FDRC_CTRL_SPC_LSB +: 8];
  wire [3:0]  step_cd  = ctrl_r[`FDRC_CTRL_STEP_LSB +: 4];
  wire [7:0]  final_s  = param_r[6];
  wire [7:0]  advance  = (scan_on && stride == 2'd2) ? 8'h02 : 8'h01;
  wire [7:0]  next_s   = cur_r + advance;
  // status register layout on select low
  wire [7:0]  msr = {(phase_r == PH_CMD) | (phase_r == PH_RES),
                     phase_r == PH_RES, 1'b0, phase_r != PH_CMD,
                     {3'b000, step_busy_r} << drive_sel};
  wire        data_ok  = pwrite ? (phase_r == PH_CMD) : (phase_r == PH_RES);
  reg  [1:0]  phase_r_nxt;
  reg         step_ev;
  wire        done_ev  = (phase_r != PH_RES) && (phase_r_nxt == PH_RES);
  wire [23:0] interval = ({20'h00000, step_cd} + 24'h000001) *
                         UNIT_CYC[23:0];

  // result bytes come only from the data register
  wire [7:0]  res_byte = (res_idx_r < 3'd3) ? flags_r[res_idx_r[1:0]] :
                         (res_idx_r == 3'd3) ? param_r[2] :
                         (res_idx_r == 3'd4) ? {7'h00, head_sel} :
                         (res_idx_r == 3'd5) ? cur_r : param_r[5];

  // ----------------------------------------------------------------
  // APB slave, one wait state
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= 1'b0;
      if (psel & penable & ~pready) begin
        pslverr <= ~mapped | (a_data & ~data_ok) | (pwrite & a_msr);
        prdata  <= 32'h00000000;
        if (!pwrite) begin
          if (a_msr)
            prdata <= {24'h000000, msr};
          // flag bytes only during result phase
          if (a_data && phase_r == PH_RES)
            prdata <= {24'h000000, res_byte};
          if (a_ctrl)
            prdata <= {16'h0000, ctrl_r};
          if (a_step)
            prdata <= {24'h000000, steps_r};
          if (a_istat)
            prdata <= {30'h0, istat_r};
          if (a_imask)
            prdata <= {30'h0, imask_r};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Software registers and interrupt
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r  <= `FDRC_CTRL_RESET;
      imask_r <= 2'b00;
      istat_r <= 2'b00;
      irq     <= 1'b0;
    end else begin
      if (wr && a_ctrl)
        ctrl_r <= pwdata[15:0];
      if (wr && a_imask)
        imask_r <= pwdata[1:0];
      // Read clears, but a same-cycle event survives
      istat_r <= ((rd && a_istat) ? 2'b00 : istat_r) | {step_ev, done_ev};
      irq     <= |(istat_r & imask_r);
    end
  end

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  always @* begin
    phase_r_nxt = phase_r;
    case (phase_r)
      PH_CMD:
        if (wr && a_data && cmd_idx_r == 4'd0 && !is_read_op(pwdata[7:0]))
          phase_r_nxt = PH_RES;
        else if (wr && a_data && cmd_idx_r == `FDRC_CMD_BYTES - 4'd1)
          phase_r_nxt = PH_REQ;
      PH_REQ:
        phase_r_nxt = PH_WAIT;
      PH_WAIT:
        if (sector_done) begin
          if ((sector_deleted != want_del) && !omit_del)
            phase_r_nxt = PH_RES;
          else if (cur_r == final_s)
            phase_r_nxt = (multi && !head_sel) ? PH_REQ : PH_RES;
          else if (next_s > spc)
            phase_r_nxt = PH_RES;
          else
            phase_r_nxt = PH_REQ;
        end
      PH_RES:
        if (rd && a_data && (res_idx_r == `FDRC_RES_BYTES - 3'd1 ||
            flags_r[0] == `FDRC_ST0_INVALID))
          phase_r_nxt = PH_CMD;
      default:
        phase_r_nxt = PH_CMD;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r    <= PH_CMD;
      cmd_idx_r  <= 4'd0;
      res_idx_r  <= 3'd0;
      cur_r      <= 8'h00;
      drive_sel  <= 2'b00;
      head_sel   <= 1'b0;
      sector_num <= 8'h00;
      sector_req <= 1'b0;
      for (i = 0; i < 9; i = i + 1)
        param_r[i] <= 8'h00;
      for (i = 0; i < 4; i = i + 1)
        flags_r[i] <= 8'h00;
    end else begin
      phase_r    <= phase_r_nxt;
      sector_req <= 1'b0;
      case (phase_r)
        PH_CMD: begin
          if (wr && a_data) begin
            param_r[cmd_idx_r] <= pwdata[7:0];
            cmd_idx_r          <= cmd_idx_r + 4'd1;
            // unknown opcode answers with one invalid flag byte
            if (cmd_idx_r == 4'd0 && !is_read_op(pwdata[7:0])) begin
              cmd_idx_r  <= 4'd0;
              flags_r[0] <= `FDRC_ST0_INVALID;
            end
            // drive number from the select bits
            if (cmd_idx_r == 4'd1) begin
              drive_sel <= pwdata[1:0];
              head_sel  <= pwdata[2];
            end
            // first sector from the record byte
            if (cmd_idx_r == 4'd4)
              cur_r <= pwdata[7:0];
            if (cmd_idx_r == `FDRC_CMD_BYTES - 4'd1) begin
              cmd_idx_r  <= 4'd0;
              flags_r[0] <= {5'h00, head_sel, drive_sel};
              flags_r[1] <= 8'h00;
              flags_r[2] <= 8'h00;
              flags_r[3] <= {5'h00, head_sel, drive_sel};
            end
          end
        end
        PH_REQ: begin
          sector_num <= cur_r;
          sector_req <= 1'b1;
        end
        PH_WAIT: begin
          if (sector_done) begin
            // marks not matching the command skipped or ending the read
            if (sector_deleted != want_del)
              flags_r[2] <= flags_r[2] | `FDRC_ST2_CTRL_MARK;
            if ((sector_deleted == want_del) || omit_del) begin
              // move to the second head at end of track
              if (cur_r == final_s && multi && !head_sel) begin
                head_sel   <= 1'b1;
                cur_r      <= 8'h01;
                flags_r[0] <= flags_r[0] | 8'h04;
              // stop past the last sector of the cylinder
              end else if (cur_r != final_s && next_s > spc) begin
                flags_r[0] <= flags_r[0] | `FDRC_ST0_ABNORMAL;
                flags_r[1] <= `FDRC_ST1_END_CYL;
              end else if (cur_r != final_s) begin
                // scan stride two takes every second sector, otherwise each following one
                cur_r <= next_s;
              end
            end
          end
        end
        PH_RES: begin
          // result bytes read out one by one
          if (rd && a_data)
            res_idx_r <= (phase_r_nxt == PH_CMD) ? 3'd0 : res_idx_r + 3'd1;
        end
        default: begin
          cmd_idx_r <= 4'd0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Head step timer
  // ----------------------------------------------------------------
  always @* begin
    step_ev = step_busy_r && steps_r == 8'h00 && timer_r == 24'h000000;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      steps_r     <= 8'h00;
      timer_r     <= 24'h000000;
      step_busy_r <= 1'b0;
      step_out    <= 1'b0;
    end else begin
      step_out <= 1'b0;
      if (timer_r != 24'h000000)
        timer_r <= timer_r - 24'h000001;
      if (wr && a_step) begin
        steps_r     <= pwdata[7:0];
        timer_r     <= 24'h000000;
        step_busy_r <= pwdata[7:0] != 8'h00;
      end else if (step_ev) begin
        step_busy_r <= 1'b0;
      // pulses spaced by the programmed interval
      end else if (steps_r != 8'h00 && timer_r == 24'h000000) begin
        step_out <= 1'b1;
        steps_r  <= steps_r - 8'h01;
        timer_r  <= interval - 24'h000001;
      end
    end
  end

endmodule

// *** src/fdrc_consts.vh ***
// Constants for the floppy read-command parameter block
`ifndef FDRC_CONSTS_VH
`define FDRC_CONSTS_VH

// ----------------------------------------------------------------
// APB register byte offsets
// ----------------------------------------------------------------
`define FDRC_ADDR_MSR      8'h00
`define FDRC_ADDR_DATA     8'h04
`define FDRC_ADDR_CTRL     8'h08
`define FDRC_ADDR_STEP     8'h0c
`define FDRC_ADDR_ISTAT    8'h10
`define FDRC_ADDR_IMASK    8'h14

// ----------------------------------------------------------------
// Control register fields and reset value
// ----------------------------------------------------------------
`define FDRC_CTRL_STEP_LSB 0
`define FDRC_CTRL_STRD_LSB 4
`define FDRC_CTRL_SCAN_BIT 6
`define FDRC_CTRL_SPC_LSB  8
`define FDRC_CTRL_RESET    16'h1a10

// ----------------------------------------------------------------
// Main status bits
// ----------------------------------------------------------------
`define FDRC_MSR_BUSY      4
`define FDRC_MSR_DIR       6
`define FDRC_MSR_READY     7

// ----------------------------------------------------------------
// Command codes and byte counts
// ----------------------------------------------------------------
`define FDRC_OP_READ       5'h06
`define FDRC_OP_READ_DEL   5'h0c
`define FDRC_CMD_BYTES     4'h9
`define FDRC_RES_BYTES     3'h7
`define FDRC_ST0_ABNORMAL  8'h40
`define FDRC_ST0_INVALID   8'h80
`define FDRC_ST1_END_CYL   8'h80
`define FDRC_ST2_CTRL_MARK 8'h40

// ----------------------------------------------------------------
// Interrupt status bits
// ----------------------------------------------------------------
`define FDRC_IRQ_DONE      0
`define FDRC_IRQ_STEP      1

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FDRC_CLK_PERIOD_NS 8
`define FDRC_STEP_UNIT_NS  1000000
`define FDRC_STEP_UNIT_CYC (`FDRC_STEP_UNIT_NS / `FDRC_CLK_PERIOD_NS)

`endif

// *** verification/fdrc_assertions.sv ***
// Port-level checker for the read-command block
`timescale 1ns/100ps
`include "fdrc_consts.vh"
module fdrc_assertions (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        irq,
  input wire [1:0]  drive_sel,
  input wire        head_sel,
  input wire [7:0]  sector_num,
  input wire        sector_req,
  input wire        sector_done,
  input wire        sector_deleted,
  input wire        step_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc_w = psel && penable;
  sequence s_wait; acc_w && !pready; endsequence
  sequence s_ans; acc_w && pready; endsequence
  AST_RDY_WAIT: assert property (s_wait |=> s_ans)
    else $error("no answer after one wait state");
  AST_RDY_ONE: assert property (pready |=> !pready)
    else $error("ready held too long");
  AST_MSR_RO: assert property (s_ans and pwrite
    && paddr == `FDRC_ADDR_MSR |-> pslverr) else $error("status written");
  AST_UNMAP: assert property (s_ans and paddr > `FDRC_ADDR_IMASK
    |-> pslverr) else $error("unmapped access accepted");
  AST_ERR_ZERO: assert property (s_ans and pslverr && !pwrite
    |-> prdata == 32'h0) else $error("refused read returned data");
  AST_REQ_PULSE: assert property (sector_req |=> !sector_req)
    else $error("sector request not a pulse");
  AST_STEP_PULSE: assert property (step_out |=> (!step_out)[*2])
    else $error("step pulses too close");
  AST_STEP_FIRST: assert property (s_ans and pwrite && !pslverr
    && paddr == `FDRC_ADDR_STEP && pwdata != 32'h0 |-> ##[1:2] step_out)
    else $error("no first step pulse");
endmodule
bind fdrc_read_cmd fdrc_assertions u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irq(irq), .drive_sel(drive_sel), .head_sel(head_sel),
  .sector_num(sector_num), .sector_req(sector_req),
  .sector_done(sector_done), .sector_deleted(sector_deleted),
  .step_out(step_out));

// *** verification/fdrc_disk_model.sv ***
// Disk-side responder for sector requests
`timescale 1ns/100ps
module fdrc_disk_model (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       sector_req,
  input  wire [2:0] dly,
  input  wire       del,
  output reg        sector_done,
  output reg        sector_deleted
);
  reg [2:0] cnt_r;
  reg       busy_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 3'h0;
      busy_r <= 1'b0;
      sector_done <= 1'b0;
      sector_deleted <= 1'b0;
    end else begin
      sector_done <= 1'b0;
      // Mark toggles outside done so a stale value never looks valid
      sector_deleted <= ~sector_deleted;
      if (sector_req) begin
        busy_r <= 1'b1;
        cnt_r <= dly;
      end else if (busy_r && cnt_r != 3'h0) begin
        cnt_r <= cnt_r - 3'h1;
      end else if (busy_r) begin
        busy_r <= 1'b0;
        sector_done <= 1'b1;
        sector_deleted <= del;
      end
    end
  end
endmodule

// *** verification/tb_fdrc_read_cmd.sv ***
// Self-checking bench for the read-command block
`timescale 1ns/100ps
`include "fdrc_consts.vh"
module tb_fdrc_read_cmd;
  reg         pclk, presetn, psel, penable, pwrite, del, er;
  reg  [7:0]  paddr, first_sec, last_sec, r;
  reg  [31:0] pwdata, seed, rd;
  wire [31:0] prdata;
  wire        pready, pslverr, irq, head_sel, sector_req, step_out;
  wire        sector_done, sector_deleted;
  wire [1:0]  drive_sel;
  wire [7:0]  sector_num;
  reg  [2:0]  dly;
  reg  [1:0]  first_drv;
  reg         last_hd;
  integer     fail_count, samples_checked, cyc, nreq, i;
  integer     steps [$];
  fdrc_read_cmd #(.UNIT_CYC(10)) dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .drive_sel(drive_sel), .head_sel(head_sel),
    .sector_num(sector_num), .sector_req(sector_req),
    .sector_done(sector_done), .sector_deleted(sector_deleted),
    .step_out(step_out));
  fdrc_disk_model disk_u (.pclk(pclk), .presetn(presetn),
    .sector_req(sector_req), .dly(dly), .del(del),
    .sector_done(sector_done), .sector_deleted(sector_deleted));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (sector_req) begin
      if (nreq == 0) first_sec = sector_num;
      if (nreq == 0) first_drv = drive_sel;
      last_sec = sector_num;
      last_hd = head_sel;
      nreq = nreq + 1;
    end
    if (step_out) steps.push_back(cyc);
  end
  function [31:0] xs(input [31:0] s);
    begin
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      xs = s ^ (s << 5);
    end
  endfunction
  // Walk the track the way the command should
  function [31:0] exp_res(input [7:0] op, b1, rec, fin, spc,
                          input s2, dl);
    reg [7:0] sec, f0, f1, f2;
    reg       hd, go, mm;
    integer   k;
    begin
      sec = rec; hd = b1[2]; f0 = 0; f1 = 0; f2 = 0; go = 1;
      mm = dl ^ (op[4:0] == `FDRC_OP_READ_DEL);
      for (k = 0; k < 40 && go; k = k + 1) begin
        if (mm) f2 = `FDRC_ST2_CTRL_MARK;
        if (mm && !op[5]) go = 0;
        else if (sec == fin && op[7] && !hd) begin
          hd = 1;
          sec = 1;
        end else if (sec == fin) go = 0;
        else if (sec + (s2 ? 2 : 1) > spc) begin
          go = 0;
          f0 = `FDRC_ST0_ABNORMAL;
          f1 = `FDRC_ST1_END_CYL;
        end else sec = sec + (s2 ? 2 : 1);
      end
      exp_res = {f0 | {5'h0, hd, b1[1:0]}, f1, f2, sec};
    end
  endfunction
  task complete_run;
    begin
      $display("Counts: %0d checked, %0d failed", samples_checked,
               fail_count);
      if (fail_count == 0 && samples_checked > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e, input string m);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
      end
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      // Sample ready at the rising edge; release only after it
      do begin
        @(posedge pclk);
        n = n + 1;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
        chk(0, 1, "bus hang");
        complete_run;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rdc(input [7:0] a, input [31:0] e);
    begin
      apb(1'b0, a, 32'h0);
      chk(rd, e, "read");
    end
  endtask
  task wait_res;
    integer n;
    begin
      n = 0;
      do begin
        apb(1'b0, `FDRC_ADDR_MSR, 32'h0);
        n = n + 1;
      end while (rd[`FDRC_MSR_DIR] !== 1'b1 && n < 200);
      chk(rd, 32'hd0, "result status");
      if (rd[`FDRC_MSR_DIR] !== 1'b1) complete_run;
    end
  endtask
  task run(input [7:0] op, rec, fin, spc, input s2, dl);
    reg [7:0]  bt [0:8];
    reg [7:0]  res [0:6];
    reg [31:0] ex;
    integer    k;
    begin
      seed = xs(seed);
      bt[0] = op | {1'b0, seed[8], 6'h0};
      bt[1] = op[7] ? seed[7:0] & 8'hfb : seed[7:0];
      bt[2] = seed[15:8]; bt[3] = {7'h0, bt[1][2]}; bt[4] = rec;
      bt[5] = seed[23:16]; bt[6] = fin; bt[7] = seed[31:24]; bt[8] = 8'hff;
      dly <= seed[26:24];
      del <= dl;
      ex = exp_res(bt[0], bt[1], rec, fin, spc, s2, dl);
      nreq = 0;
      for (k = 0; k < 9; k = k + 1) begin
        rdc(`FDRC_ADDR_MSR, 32'h80);
        apb(1'b1, `FDRC_ADDR_DATA, bt[k]);
      end
      wait_res;
      chk(irq, 1'b1, "done irq");
      apb(1'b1, `FDRC_ADDR_DATA, 32'h0);
      chk(er, 1'b1, "result write");
      for (k = 0; k < 7; k = k + 1) begin
        rdc(`FDRC_ADDR_MSR, 32'hd0);
        apb(1'b0, `FDRC_ADDR_DATA, 32'h0);
        res[k] = rd[7:0];
      end
      chk(res[0], ex[31:24], "flags0");
      chk(res[1], ex[23:16], "flags1");
      chk(res[2], ex[15:8], "flags2");
      chk(res[3], seed[15:8], "cylinder");
      chk(res[4], {7'h0, ex[26]}, "head");
      chk(res[5], ex[7:0], "record");
      chk(res[6], seed[23:16], "size");
      chk(first_sec, rec, "first sector");
      chk(first_drv, ex[25:24], "drive");
      chk(last_sec, ex[7:0], "last sector");
      chk(last_hd, ex[26], "last head");
      rdc(`FDRC_ADDR_MSR, 32'h80);
      rdc(`FDRC_ADDR_ISTAT, 32'h1);
      // Interrupt line trails the status clear by one register stage
      repeat (2) @(posedge pclk);
      chk(irq, 1'b0, "irq cleared");
      $display("test op %h done", op);
    end
  endtask
  initial begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    dly = 0; del = 0; seed = 32'h9acc; fail_count = 0; samples_checked = 0;
    cyc = 0; nreq = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`FDRC_ADDR_CTRL, `FDRC_CTRL_RESET);
    rdc(`FDRC_ADDR_MSR, 32'h80);
    apb(1'b1, `FDRC_ADDR_MSR, 32'h0);
    chk(er, 1'b1, "status write");
    rdc(8'h18, 32'h0);
    chk(er, 1'b1, "unmapped");
    rdc(`FDRC_ADDR_DATA, 32'h0);
    chk(er, 1'b1, "early result read");
    apb(1'b1, `FDRC_ADDR_IMASK, 32'h1);
    $display("test access done");
    seed = xs(seed);
    r = {4'h0, seed[3:0]} + 8'h1;
    run(8'h06, r, r, 8'h1a, 0, 0);
    run(8'h0c, r, r + 8'h1, 8'h1a, 0, 1);
    run(8'h26, r, r + 8'h1, 8'h1a, 0, 1);
    run(8'h06, r, r + 8'h1, 8'h1a, 0, 1);
    run(8'h86, 8'h1, 8'h2, 8'h1a, 0, 0);
    apb(1'b1, `FDRC_ADDR_CTRL, 32'h1a50);
    run(8'h06, 8'h19, 8'hff, 8'h1a, 0, 0);
    apb(1'b1, `FDRC_ADDR_CTRL, 32'h1a60);
    run(8'h06, 8'h17, 8'hff, 8'h1a, 1, 0);
    apb(1'b1, `FDRC_ADDR_DATA, 32'h1f);
    wait_res;
    rdc(`FDRC_ADDR_DATA, `FDRC_ST0_INVALID);
    rdc(`FDRC_ADDR_MSR, 32'h80);
    apb(1'b0, `FDRC_ADDR_ISTAT, 32'h0);
    $display("test invalid done");
    apb(1'b1, `FDRC_ADDR_IMASK, 32'h0);
    apb(1'b1, `FDRC_ADDR_CTRL, 32'h1a11);
    steps.delete();
    apb(1'b1, `FDRC_ADDR_STEP, 32'h3);
    rdc(`FDRC_ADDR_MSR, 32'h80 | (32'h1 << first_drv));
    repeat (120) @(posedge pclk);
    chk(steps.size(), 3, "step count");
    for (i = 1; i < steps.size(); i = i + 1)
      chk(steps[i] - steps[i-1], 20, "step gap");
    chk(irq, 1'b0, "masked irq");
    apb(1'b1, `FDRC_ADDR_IMASK, 32'h2);
    repeat (3) @(posedge pclk);
    chk(irq, 1'b1, "step irq");
    rdc(`FDRC_ADDR_ISTAT, 32'h2);
    rdc(`FDRC_ADDR_STEP, 32'h0);
    $display("test step done");
    complete_run;
  end
endmodule
